// ==== logic/tmc_pkg.sv ====
// Package: register map, field layout and timing constants for the dual timer block
package tmc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TMC_OFS_CTRL = 8'h00; // timer_run_flag_control
  localparam logic [7:0] TMC_OFS_MODE = 8'h04; // timer_mode_select
  localparam logic [7:0] TMC_OFS_T0LO = 8'h08;
  localparam logic [7:0] TMC_OFS_T0HI = 8'h0c;
  localparam logic [7:0] TMC_OFS_T1LO = 8'h10;
  localparam logic [7:0] TMC_OFS_T1HI = 8'h14;
  localparam logic [7:0] TMC_OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] TMC_OFS_IRQ_CLR = 8'h1c;
  localparam logic [7:0] TMC_OFS_IRQ_EN = 8'h20;
  localparam logic [7:0] TMC_OFS_BITOP = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TMC_CTL_TF1 = 7;
  localparam int TMC_CTL_TR1 = 6;
  localparam int TMC_CTL_TF0 = 5;
  localparam int TMC_CTL_TR0 = 4;
  localparam int TMC_CTL_IE1 = 3;
  localparam int TMC_CTL_IT1 = 2;
  localparam int TMC_CTL_IE0 = 1;
  localparam int TMC_CTL_IT0 = 0;
  localparam int TMC_MOD_GATE1 = 7;
  localparam int TMC_MOD_CT1 = 6;
  localparam int TMC_MOD_M1_HI = 5;
  localparam int TMC_MOD_M1_LO = 4;
  localparam int TMC_MOD_GATE0 = 3;
  localparam int TMC_MOD_CT0 = 2;
  localparam int TMC_MOD_M0_HI = 1;
  localparam int TMC_MOD_M0_LO = 0;
  localparam int TMC_BITOP_VAL = 3; // bit op: [2:0] index, [3] value
  localparam int TMC_EVT_TF0 = 0; // status / enable / clear layout
  localparam int TMC_EVT_TF1 = 1;
  localparam int TMC_EVT_IE0 = 2;
  localparam int TMC_EVT_IE1 = 3;
  localparam int TMC_PIN_T0 = 0; // pin vector layout
  localparam int TMC_PIN_T1 = 1;
  localparam int TMC_PIN_INT0 = 2;
  localparam int TMC_PIN_INT1 = 3;
  localparam int TMC_NPINS = 4;
  localparam int TMC_NEVT = 4;

  // ----------------------------------------------------------------
  // Modes, reset values and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] TMC_MODE_13BIT = 2'h0;
  localparam logic [1:0] TMC_MODE_16BIT = 2'h1;
  localparam logic [1:0] TMC_MODE_RELOAD = 2'h2;
  localparam logic [1:0] TMC_MODE_SPLIT = 2'h3;
  localparam logic [7:0] TMC_RST_CTRL = 8'h00;
  localparam logic [7:0] TMC_RST_MODE = 8'h00;
  localparam logic [7:0] TMC_RST_BYTE = 8'h00;
  localparam logic [4:0] TMC_LO13_MAX = 5'h1f;
  localparam int TMC_CLK_HZ = 40_000_000;
  localparam int TMC_OSC_PER_MC = 12; // oscillator periods per machine cycle
  localparam int TMC_MC_CLKS = TMC_OSC_PER_MC; // clk is the oscillator
  localparam int TMC_PRESC_W = 4;

  typedef enum logic {
    TMC_BUS_IDLE = 1'b0,
    TMC_BUS_ACK = 1'b1
  } tmc_bus_t;

  // Result of one count step on a timer pair
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic ovf;
  } tmc_step_t;

  typedef struct packed {
    logic [TMC_NPINS-1:0] meta;
    logic [TMC_NPINS-1:0] sync;
    logic [TMC_NPINS-1:0] samp;
    logic [TMC_NPINS-1:0] fall;
  } tmc_sync_t;

  typedef struct packed {
    logic [TMC_PRESC_W-1:0] cnt;
  } tmc_presc_t;

  typedef struct packed {
    tmc_bus_t bus;
    logic [31:0] rdat;
    logic [7:0] ctl;
    logic [7:0] mode;
    logic [7:0] t0lo;
    logic [7:0] t0hi;
    logic [7:0] t1lo;
    logic [7:0] t1hi;
    logic [TMC_NEVT-1:0] stat;
    logic [TMC_NEVT-1:0] en;
    logic [2:0] bitIdx;
  } tmc_state_t;

endpackage : tmc_pkg

// ==== logic/tmc_prescale.sv ====
// Machine cycle strobe: one clk pulse out of every machine cycle
`timescale 1ns/1ps
module tmc_prescale
  import tmc_pkg::*;
#(
  parameter int DIV = TMC_MC_CLKS
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic tick
);

  tmc_presc_t s_q;
  tmc_presc_t s_d;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Counts 0..DIV-1 and wraps; tick marks the last clock of the cycle
  always_comb begin
    s_d = s_q;
    if (s_q.cnt == TMC_PRESC_W'(DIV - 1)) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  assign tick = (s_q.cnt == TMC_PRESC_W'(DIV - 1));

  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : tmc_prescale

// ==== logic/tmc_pin_sync.sv ====
// Pin synchroniser with once-per-machine-cycle sampling and fall detection
`timescale 1ns/1ps
module tmc_pin_sync
  import tmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic [TMC_NPINS-1:0] pins,
  output logic [TMC_NPINS-1:0] level,
  output logic [TMC_NPINS-1:0] sample,
  output logic [TMC_NPINS-1:0] fall
);

  tmc_sync_t s_q;
  tmc_sync_t s_d;

  // ----------------------------------------------------------------
  // Two-stage synchroniser and machine-cycle sampler
  // ----------------------------------------------------------------
  // Only sync reads meta; samples move once per machine cycle so a 1-to-0
  // needs two machine cycles to be seen, as the count rate limit expects
  always_comb begin
    s_d = s_q;
    s_d.meta = pins;
    s_d.sync = s_q.meta;
    s_d.fall = '0;
    if (tick) begin
      s_d.samp = s_q.sync;
      s_d.fall = s_q.samp & ~s_q.sync; // high then low
    end
  end

  assign level = s_q.sync;
  assign sample = s_q.samp;
  assign fall = s_q.fall;

  // Pins idle high, so reset the chain to ones to avoid a false fall
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '{meta: '1, sync: '1, samp: '1, fall: '0};
    end else begin
      s_q <= s_d;
    end
  end

endmodule : tmc_pin_sync

// ==== logic/tmc_dual_timer.sv ====
// Dual 16-bit timer/counter with mode control and a Wishbone register port
`timescale 1ns/1ps

// Notes on behaviour
// R1 - Hardware sets overflow flag on rollover
// R2 - Vectoring to handler clears overflow flag
// R3 - Gate set: run bit and pin high
// R4 - Mode 00 is a 13-bit timer
// R5 - Mode 01 is a 16-bit timer
// R6 - Mode 10 reloads low byte from high
// R7 - Split mode: low byte keeps timer 0 controls
// R8 - Split high byte uses timer 1 run/flag
// R9 - Timer 1 mode 11 holds its count
// R10 - Control register has single-bit set/clear/test
// R11 - Mode register is whole-byte only
// R12 - Only software changes the run bits
// R13 - Timer counts once per machine cycle
// R14 - Counter counts sampled falling edges
// R15 - 13-bit count: high byte plus low five
// R16 - Type bit picks level or falling edge
module tmc_dual_timer
  import tmc_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // External count and interrupt pins
  input wire logic countPin0,
  input wire logic countPin1,
  input wire logic externalIrqPin0B,
  input wire logic externalIrqPin1B,
  // Processor vectoring strobes
  input wire logic vectorTimer0,
  input wire logic vectorTimer1,
  input wire logic vectorExt0,
  input wire logic vectorExt1,
  // Request flags towards the core
  output logic timer0OverflowFlag,
  output logic timer1OverflowFlag,
  output logic extIrq0Flag,
  output logic extIrq1Flag,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tmc_state_t s_q;
  tmc_state_t s_d;
  logic mcTick;
  logic [TMC_NPINS-1:0] pinLevel;
  logic [TMC_NPINS-1:0] pinSample;
  logic [TMC_NPINS-1:0] pinFall;
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic split0;
  logic run0;
  logic run1;
  logic inc0;
  logic inc1;
  logic incHi0;
  logic [7:0] ctlSw;
  logic [TMC_NEVT-1:0] evt;
  logic busReq;
  logic wrStb;
  logic [7:0] wrByte;
  tmc_step_t step0;
  tmc_step_t step1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One count step of a timer pair in modes 00, 01 and 10
  function automatic tmc_step_t stepTimer(
    input logic [7:0] hi,
    input logic [7:0] lo,
    input logic [1:0] mode,
    input logic inc
  );
    tmc_step_t r;
    r.hi = hi;
    r.lo = lo;
    r.ovf = 1'b0;
    if (inc) begin
      case (mode)
        TMC_MODE_13BIT: begin
          // Upper three low bits are left alone, software must ignore them
          r.lo[4:0] = lo[4:0] + 5'h01; // R15
          if (lo[4:0] == TMC_LO13_MAX) begin
            r.hi = hi + 8'h01;
            r.ovf = (hi == 8'hff); // R4
          end
        end
        TMC_MODE_16BIT: begin
          {r.hi, r.lo} = {hi, lo} + 16'h0001; // R5
          r.ovf = ({hi, lo} == 16'hffff);
        end
        TMC_MODE_RELOAD: begin
          r.ovf = (lo == 8'hff);
          r.lo = r.ovf ? hi : lo + 8'h01; // R6
        end
        default: begin
          r.ovf = 1'b0;
        end
      endcase
    end
    return r;
  endfunction : stepTimer

  // Read mux over the register map; unmapped offsets read as zero
  function automatic logic [31:0] readReg(input tmc_state_t s, input logic [AW-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (8'(a))
      TMC_OFS_CTRL: v = s.ctl;
      TMC_OFS_MODE: v = s.mode;
      TMC_OFS_T0LO: v = s.t0lo;
      TMC_OFS_T0HI: v = s.t0hi;
      TMC_OFS_T1LO: v = s.t1lo;
      TMC_OFS_T1HI: v = s.t1hi;
      TMC_OFS_IRQ_STAT: v = {4'h0, s.stat};
      TMC_OFS_IRQ_EN: v = {4'h0, s.en};
      TMC_OFS_BITOP: v = {7'h00, s.ctl[s.bitIdx]}; // R10
      default: v = 8'h00;
    endcase
    return {24'h000000, v};
  endfunction : readReg

  // ----------------------------------------------------------------
  // Machine cycle and pins
  // ----------------------------------------------------------------
  tmc_prescale #(
    .DIV(TMC_MC_CLKS)
  ) uPrescale (
    .clk(clk),
    .rst_b(rst_b),
    .tick(mcTick)
  );

  tmc_pin_sync uPinSync (
    .clk(clk),
    .rst_b(rst_b),
    .tick(mcTick),
    .pins({externalIrqPin1B, externalIrqPin0B, countPin1, countPin0}),
    .level(pinLevel),
    .sample(pinSample),
    .fall(pinFall)
  );

  // ----------------------------------------------------------------
  // Run conditions and count enables
  // ----------------------------------------------------------------
  assign mode0 = s_q.mode[TMC_MOD_M0_HI:TMC_MOD_M0_LO];
  assign mode1 = s_q.mode[TMC_MOD_M1_HI:TMC_MOD_M1_LO];
  assign split0 = (mode0 == TMC_MODE_SPLIT);
  assign run0 = s_q.ctl[TMC_CTL_TR0] & (~s_q.mode[TMC_MOD_GATE0] | pinLevel[TMC_PIN_INT0]); // R3 R7
  // Timer 1 loses its run bit to the split high byte, so it free-runs then
  assign run1 = split0 ? 1'b1 :
                s_q.ctl[TMC_CTL_TR1] & (~s_q.mode[TMC_MOD_GATE1] | pinLevel[TMC_PIN_INT1]); // R3
  // Timer function counts machine cycles, counter function counts falls
  assign inc0 = run0 & (s_q.mode[TMC_MOD_CT0] ? pinFall[TMC_PIN_T0] : mcTick); // R13 R14
  assign inc1 = run1 & (s_q.mode[TMC_MOD_CT1] ? pinFall[TMC_PIN_T1] : mcTick); // R13 R14
  assign incHi0 = split0 & s_q.ctl[TMC_CTL_TR1] & mcTick; // R8

  // Timer 0 in split mode steps its low byte as a plain 8-bit counter
  always_comb begin
    if (split0) begin
      step0.hi = s_q.t0hi + {7'h00, incHi0};
      step0.lo = s_q.t0lo + {7'h00, inc0}; // R7
      step0.ovf = inc0 & (s_q.t0lo == 8'hff);
    end else begin
      step0 = stepTimer(s_q.t0hi, s_q.t0lo, mode0, inc0);
    end
  end

  // Mode 11 on timer 1 freezes it
  always_comb begin
    if (mode1 == TMC_MODE_SPLIT) begin
      step1 = '{hi: s_q.t1hi, lo: s_q.t1lo, ovf: 1'b0}; // R9
    end else begin
      step1 = stepTimer(s_q.t1hi, s_q.t1lo, mode1, inc1);
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign busReq = cyc_i & stb_i;
  assign wrStb = (s_q.bus == TMC_BUS_ACK) & busReq & we_i & sel_i[0];
  assign wrByte = dat_i[7:0];
  assign ack_o = (s_q.bus == TMC_BUS_ACK);
  assign dat_o = s_q.rdat;

  // Software view of the control byte before hardware updates
  always_comb begin
    ctlSw = s_q.ctl;
    if (wrStb && 8'(adr_i) == TMC_OFS_CTRL) begin
      ctlSw = wrByte;
    end
    if (wrStb && 8'(adr_i) == TMC_OFS_BITOP) begin
      ctlSw[wrByte[2:0]] = wrByte[TMC_BITOP_VAL]; // R10
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    evt = '0;

    // Bus phase: answer one cycle after the request, drop ack after one
    case (s_q.bus)
      TMC_BUS_IDLE: begin
        if (busReq) begin
          s_d.bus = TMC_BUS_ACK;
          s_d.rdat = we_i ? s_q.rdat : readReg(s_q, adr_i); // Writes keep the last read data
        end
      end
      TMC_BUS_ACK: begin
        s_d.bus = TMC_BUS_IDLE;
      end
      default: begin
        s_d.bus = TMC_BUS_IDLE;
      end
    endcase

    // Counts step first, a software write to the same byte wins
    s_d.t0lo = step0.lo;
    s_d.t0hi = step0.hi;
    s_d.t1lo = step1.lo;
    s_d.t1hi = step1.hi;
    if (wrStb) begin
      case (8'(adr_i))
        TMC_OFS_MODE: s_d.mode = wrByte; // R11
        TMC_OFS_T0LO: s_d.t0lo = wrByte;
        TMC_OFS_T0HI: s_d.t0hi = wrByte;
        TMC_OFS_T1LO: s_d.t1lo = wrByte;
        TMC_OFS_T1HI: s_d.t1hi = wrByte;
        TMC_OFS_IRQ_EN: s_d.en = wrByte[TMC_NEVT-1:0];
        TMC_OFS_BITOP: s_d.bitIdx = wrByte[2:0];
        default: begin
        end
      endcase
    end

    // Control byte: software value, then vector clears, then hardware sets;
    // run bits pass straight from software and nothing else touches them
    s_d.ctl = ctlSw; // R12
    if (vectorTimer0) begin
      s_d.ctl[TMC_CTL_TF0] = 1'b0; // R2
    end
    if (vectorTimer1) begin
      s_d.ctl[TMC_CTL_TF1] = 1'b0; // R2
    end
    if (step0.ovf) begin
      s_d.ctl[TMC_CTL_TF0] = 1'b1; // R1
      evt[TMC_EVT_TF0] = 1'b1;
    end
    // In split mode the timer 1 flag belongs to the high byte of timer 0
    if (split0 ? (incHi0 && s_q.t0hi == 8'hff) : step1.ovf) begin
      s_d.ctl[TMC_CTL_TF1] = 1'b1; // R1 R8
      evt[TMC_EVT_TF1] = 1'b1;
    end

    // External interrupt flags: edge mode latches a sampled fall until
    // vectoring, level mode simply follows the sampled pin
    if (ctlSw[TMC_CTL_IT0]) begin
      if (vectorExt0) begin
        s_d.ctl[TMC_CTL_IE0] = 1'b0;
      end
      if (pinFall[TMC_PIN_INT0]) begin
        s_d.ctl[TMC_CTL_IE0] = 1'b1; // R16
      end
    end else begin
      s_d.ctl[TMC_CTL_IE0] = ~pinSample[TMC_PIN_INT0]; // R16
    end
    if (ctlSw[TMC_CTL_IT1]) begin
      if (vectorExt1) begin
        s_d.ctl[TMC_CTL_IE1] = 1'b0;
      end
      if (pinFall[TMC_PIN_INT1]) begin
        s_d.ctl[TMC_CTL_IE1] = 1'b1; // R16
      end
    end else begin
      s_d.ctl[TMC_CTL_IE1] = ~pinSample[TMC_PIN_INT1]; // R16
    end
    evt[TMC_EVT_IE0] = s_d.ctl[TMC_CTL_IE0] & ~s_q.ctl[TMC_CTL_IE0];
    evt[TMC_EVT_IE1] = s_d.ctl[TMC_CTL_IE1] & ~s_q.ctl[TMC_CTL_IE1];

    // Sticky status: a new event beats a clear in the same cycle
    if (wrStb && 8'(adr_i) == TMC_OFS_IRQ_CLR) begin
      s_d.stat = s_q.stat & ~wrByte[TMC_NEVT-1:0];
    end
    s_d.stat = s_d.stat | evt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign timer0OverflowFlag = s_q.ctl[TMC_CTL_TF0];
  assign timer1OverflowFlag = s_q.ctl[TMC_CTL_TF1];
  assign extIrq0Flag = s_q.ctl[TMC_CTL_IE0];
  assign extIrq1Flag = s_q.ctl[TMC_CTL_IE1];
  assign irq = |(s_q.stat & s_q.en); // Level, high while any enabled bit set

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '{bus: TMC_BUS_IDLE, rdat: '0, ctl: TMC_RST_CTRL, mode: TMC_RST_MODE,
               t0lo: TMC_RST_BYTE, t0hi: TMC_RST_BYTE, t1lo: TMC_RST_BYTE,
               t1hi: TMC_RST_BYTE, stat: '0, en: '0, bitIdx: '0};
    end else begin
      s_q <= s_d;
    end
  end

endmodule : tmc_dual_timer

// ==== dv/tmc_dual_timer_asserts.sv ====
// Port checker for the dual timer block
`timescale 1ns/1ps
module tmc_dual_timer_asserts
  import tmc_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [AW-1:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic vectorTimer0,
  input wire logic vectorTimer1,
  input wire logic timer0OverflowFlag,
  input wire logic timer1OverflowFlag
);
  // ----------------------------------------------------------------
  // Bus answer and vector clears
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ack_next;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  property p_ack_cause;
    ack_o |-> $past(cyc_i && stb_i);
  endproperty
  property p_rd_hi;
    ack_o |-> dat_o[31:8] == 24'h0;
  endproperty
  // Read data must not drift between reads, software may sample it late
  property p_rd_hold;
    !(cyc_i && stb_i && !we_i && !ack_o) |=> $stable(dat_o);
  endproperty
  property p_clr_read;
    cyc_i && stb_i && !we_i && !ack_o && adr_i == TMC_OFS_IRQ_CLR |=> dat_o == 32'h0;
  endproperty
  property p_vec0;
    vectorTimer0 |=> !timer0OverflowFlag;
  endproperty
  property p_vec1;
    vectorTimer1 |=> !timer1OverflowFlag;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed");
  a_clr_read: assert property (p_clr_read) else $error("clear register read nonzero");
  a_vec0: assert property (p_vec0) else $error("timer 0 flag kept after vector");
  a_vec1: assert property (p_vec1) else $error("timer 1 flag kept after vector");
  c_vec0: cover property (vectorTimer0 && timer0OverflowFlag);
  c_vec1: cover property (vectorTimer1);
  c_read: cover property (ack_o && !we_i);
endmodule : tmc_dual_timer_asserts

// ==== dv/tmc_core_model.sv ====
// Processor-side model: vectors to each handler once its flag is seen
`timescale 1ns/1ps
module tmc_core_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic autoVec,
  input wire logic slow,
  input wire logic [3:0] flags,
  output logic [3:0] vec
);
  logic [3:0] vecQ;
  logic [3:0] flagQ;
  // One pulse per request; slow answers a cycle late, as a busy core would
  assign vec = autoVec ? ((slow ? flagQ : flags) & flags & ~vecQ) : 4'h0;
  // Remember the last pulse so a draining flag is not vectored twice
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      vecQ <= 4'h0;
      flagQ <= 4'h0;
    end else begin
      vecQ <= vec;
      flagQ <= flags;
    end
  end
endmodule : tmc_core_model

// ==== dv/tb_top.sv ====
// Self-checking bench for the dual timer block
`timescale 1ns/1ps
module tb_top;
  import tmc_pkg::*;
  logic clk, rst_b, cyc, stb, we, cp0, ip0B, autoVec, slow;
  logic [7:0] adr;
  logic [31:0] wdat;
  wire logic [31:0] rdat;
  wire logic ack, irq;
  wire logic [3:0] flg, vec;
  logic [2:0] bits [6] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
  int failCount = 0, checksDone = 0, cycles = 0, n;
  tmc_dual_timer u_tmc_dual_timer (.clk(clk), .rst_b(rst_b), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .countPin0(cp0),
    .countPin1(cp0), .externalIrqPin0B(ip0B), .externalIrqPin1B(ip0B), .vectorTimer0(vec[0]),
    .vectorTimer1(vec[1]), .vectorExt0(vec[2]), .vectorExt1(vec[3]), .timer0OverflowFlag(flg[0]),
    .timer1OverflowFlag(flg[1]), .extIrq0Flag(flg[2]), .extIrq1Flag(flg[3]), .irq(irq));
  tmc_core_model u_tmc_core_model (.clk(clk), .rst_b(rst_b), .autoVec(autoVec), .slow(slow),
    .flags(flg), .vec(vec));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard: the whole run needs under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount++;
      tallyAndFinish();
    end
  end
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    // No wait limit here: the hang guard ends a lost answer
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm, input logic [31:0] m = '1);
    logic [31:0] q;
    bus(1'b0, a, 8'h0, q);
    chk(nm, q & m, e);
  endtask : rd
  task automatic waitf(input logic [3:0] m);
    int k;
    k = 0;
    while ((flg & m) !== m && k < 80) begin
      @(posedge clk);
      k++;
    end
    chk("flag wait", {28'h0, flg & m}, {28'h0, m});
  endtask : waitf
  // Load timer 0, run it to overflow, then stop it and read back the count
  task automatic ovf(input logic [7:0] md, hi, lo, ctl, input logic [3:0] ef, input logic [7:0] eh, el,
    input logic hold);
    wr(TMC_OFS_CTRL, 8'h00);
    wr(TMC_OFS_MODE, md);
    wr(TMC_OFS_T0LO, lo);
    wr(TMC_OFS_T0HI, hi);
    wr(TMC_OFS_CTRL, ctl);
    if (hold) begin
      repeat (48) @(posedge clk);
      chk("held", {30'h0, flg[1:0]}, 32'h0);
      ip0B <= 1'b1;
      cp0 <= 1'b0;
    end
    waitf(ef);
    chk("flags", {30'h0, flg[1:0]}, {28'h0, ef});
    // With no flag expected the core is vectoring, so the timer 0 flag may be caught mid-pulse
    rd(TMC_OFS_CTRL, {24'h0, ctl | {ef[1], 1'b0, ef[0], 5'h0}}, "ctrl", ef == 4'h0 ? 32'hd0 : 32'hf0);
    wr(TMC_OFS_CTRL, 8'h00);
    rd(TMC_OFS_T0HI, {24'h0, eh}, "t0hi");
    rd(TMC_OFS_T0LO, {24'h0, el}, "t0lo", md[1:0] == 2'h0 ? 32'h1f : 32'hff);
  endtask : ovf
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tallyAndFinish
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b, cyc, stb, we, cp0, autoVec, slow} = '0;
    ip0B = 1'b1;
    adr = 8'h0;
    wdat = 32'h0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(TMC_OFS_CTRL, {24'h0, TMC_RST_CTRL}, "ctrl reset");
    rd(TMC_OFS_MODE, {24'h0, TMC_RST_MODE}, "mode reset");
    rd(8'h3c, 32'h0, "unmapped");
    wr(TMC_OFS_MODE, 8'ha5);
    rd(TMC_OFS_MODE, 32'ha5, "mode byte");
    wr(TMC_OFS_MODE, 8'h00);
    foreach (bits[i]) begin
      wr(TMC_OFS_BITOP, {5'h01, bits[i]});
      rd(TMC_OFS_BITOP, 32'h1, "bit test set");
      rd(TMC_OFS_CTRL, 32'h1 << bits[i], "bit set");
      wr(TMC_OFS_BITOP, {5'h00, bits[i]});
      rd(TMC_OFS_BITOP, 32'h0, "bit test clear");
    end
    $display("test registers done");
    wr(TMC_OFS_IRQ_CLR, 8'h0f);
    wr(TMC_OFS_IRQ_EN, 8'h01);
    ovf(8'h01, 8'hff, 8'hfe, 8'h10, 4'h1, 8'h00, 8'h00, 1'b0);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(TMC_OFS_IRQ_STAT, 32'h1, "status");
    wr(TMC_OFS_IRQ_EN, 8'h00);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(TMC_OFS_IRQ_EN, 8'h01);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    wr(TMC_OFS_IRQ_STAT, 8'h0f);
    rd(TMC_OFS_IRQ_STAT, 32'h1, "status read-only");
    wr(TMC_OFS_IRQ_CLR, 8'h01);
    rd(TMC_OFS_IRQ_CLR, 32'h0, "clear reads zero");
    rd(TMC_OFS_IRQ_STAT, 32'h0, "status cleared");
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(TMC_OFS_IRQ_EN, 8'h00);
    $display("test interrupt done");
    ovf(8'h00, 8'hff, 8'h1e, 8'h10, 4'h1, 8'h00, 8'h00, 1'b0);
    ovf(8'h02, 8'h80, 8'hff, 8'h10, 4'h1, 8'h80, 8'h80, 1'b0);
    ovf(8'h03, 8'hff, 8'hff, 8'h50, 4'h3, 8'h00, 8'h00, 1'b0);
    ovf(8'h03, 8'hff, 8'hff, 8'h10, 4'h1, 8'hff, 8'h00, 1'b0);
    ip0B <= 1'b0;
    ovf(8'h09, 8'hff, 8'hff, 8'h10, 4'h1, 8'h00, 8'h00, 1'b1);
    cp0 <= 1'b1;
    ovf(8'h05, 8'hff, 8'hff, 8'h10, 4'h1, 8'h00, 8'h00, 1'b1);
    $display("test modes done");
    wr(TMC_OFS_MODE, 8'h30);
    wr(TMC_OFS_T1LO, 8'hff);
    wr(TMC_OFS_T1HI, 8'hff);
    wr(TMC_OFS_CTRL, 8'h40);
    repeat (48) @(posedge clk);
    chk("timer 1 stopped", {31'h0, flg[1]}, 32'h0);
    rd(TMC_OFS_T1LO, 32'hff, "timer 1 held");
    wr(TMC_OFS_MODE, 8'h10);
    waitf(4'h2);
    $display("test timer 1 done");
    // Reload from 0xff overflows every machine cycle; the core vectors each one
    autoVec <= 1'b1;
    ovf(8'h02, 8'hff, 8'hff, 8'h10, 4'h0, 8'hff, 8'hff, 1'b0);
    wr(TMC_OFS_CTRL, 8'h10);
    waitf(4'h1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((flg[0] !== 1'b1 || n < 2) && n < 40);
    chk("machine cycle", n, TMC_MC_CLKS);
    autoVec <= 1'b0;
    wr(TMC_OFS_CTRL, 8'h01);
    slow <= 1'b1;
    ip0B <= 1'b0;
    waitf(4'h4);
    autoVec <= 1'b1;
    repeat (4) @(posedge clk);
    chk("edge flag vectored", {31'h0, flg[2]}, 32'h0);
    autoVec <= 1'b0;
    wr(TMC_OFS_CTRL, 8'h00);
    // Both interrupt pins share one drive, so both level flags must follow it
    waitf(4'hc);
    ip0B <= 1'b1;
    repeat (40) @(posedge clk);
    chk("level flags follow pins", {30'h0, flg[3:2]}, 32'h0);
    $display("test vectoring done");
    tallyAndFinish();
  end
endmodule : tb_top
bind tmc_dual_timer tmc_dual_timer_asserts #(.AW(AW)) u_tmc_dual_timer_asserts (.clk(clk), .rst_b(rst_b),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .vectorTimer0(vectorTimer0), .vectorTimer1(vectorTimer1), .timer0OverflowFlag(timer0OverflowFlag),
  .timer1OverflowFlag(timer1OverflowFlag));
